// ### shared/pdb_regs.vh
// constants of the dead-band stage: field widths, reset values, codes
// assumes inclusion by the dead-band logic files only
`ifndef PDB_REGS_VH
`define PDB_REGS_VH

// ============================================================
// dead-time counters and registers
`define PDB_DT_W 8
`define PDB_DT_MSB 7
`define PDB_DT_RST 8'h00
`define PDB_DT_ZERO 8'h00
`define PDB_DT_ONE 8'h01

// ============================================================
// prescaler select codes and divider counter
`define PDB_PS_W 2
`define PDB_PS_DIV1 2'h0
`define PDB_PS_DIV2 2'h1
`define PDB_PS_DIV4 2'h2
`define PDB_PS_DIV8 2'h3
`define PDB_PS_CNT_W 3
`define PDB_PS_CNT_RST 3'h0
`define PDB_PS_CNT_ONE 3'h1
`define PDB_PS_MASK1 3'h0
`define PDB_PS_MASK2 3'h1
`define PDB_PS_MASK4 3'h3
`define PDB_PS_MASK8 3'h7

// ============================================================
// channel states
`define PDB_ST_W 2
`define PDB_ST_IDLE 2'h0
`define PDB_ST_RISE 2'h1
`define PDB_ST_FALL 2'h2

`endif

// ### logic/pdb_prescale.v
// controller clock prescaler: one-cycle enable pulse at clk/1,2,4,8
// assumes clk is the selected source clock and sel is quasi-static
`timescale 1ns/100ps
`default_nettype none
`include "pdb_regs.vh"

module pdb_prescale (
    input wire clk, // source clock, 40 MHz
    input wire sys_rst, // asynchronous reset, active high
    input wire [`PDB_PS_W-1:0] sel, // divide select 1,2,4,8
    output wire tick // one-cycle controller clock enable
);

    reg [`PDB_PS_CNT_W-1:0] cnt_q;
    reg [`PDB_PS_CNT_W-1:0] mask;

    // ============================================================
    // divider
    always @* begin
        case (sel)
            `PDB_PS_DIV1: mask = `PDB_PS_MASK1; // RULE15
            `PDB_PS_DIV2: mask = `PDB_PS_MASK2; // RULE15
            `PDB_PS_DIV4: mask = `PDB_PS_MASK4; // RULE15
            `PDB_PS_DIV8: mask = `PDB_PS_MASK8; // RULE15
            default: mask = `PDB_PS_MASK1;
        endcase
    end

    // free-running count; a select change may shorten one period
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= `PDB_PS_CNT_RST;
        end else begin
            cnt_q <= cnt_q + `PDB_PS_CNT_ONE;
        end
    end

    assign tick = ((cnt_q & mask) == mask); // RULE15

endmodule
`default_nettype wire

// ### logic/pdb_dead_band.v
// dead-band insertion stage of a switch-mode pwm controller
// assumes edge and period events are one-cycle pulses synchronous to clk
//
// Overview of operation
// RULE1 - dead time only in complementary or direction-change modes
// RULE2 - two independent 8-bit dead-time counters
// RULE3 - rising event delays primary turn-on
// RULE4 - falling event delays complementary turn-on
// RULE5 - rising time applied at period after load
// RULE6 - falling time applied at period after load
// RULE7 - rising insertion gated by its enable
// RULE8 - falling insertion gated by its enable
// RULE9 - enable changes act immediately
// RULE10 - counters advance on each controller clock
// RULE11 - async events may add one clock
// RULE12 - falling during rising count: switch, suppress primary
// RULE13 - rising during falling count: switch, suppress complementary
// RULE14 - same edge restarts count, outputs frozen
// RULE15 - controller clock is source divided 1,2,4,8
// RULE16 - delay equals programmed count, zero adds none
`timescale 1ns/100ps
`default_nettype none
`include "pdb_regs.vh"

module pdb_dead_band (
    input wire clk, // 40 MHz source clock
    input wire sys_rst, // asynchronous reset, active high
    input wire ctrl_enable, // controller enabled
    input wire comp_mode, // complementary-drive mode selected
    input wire bridge_dir_change, // full-bridge direction change in progress
    input wire rising_dead_time_enable, // rising insertion enable
    input wire falling_dead_time_enable, // falling insertion enable
    input wire [`PDB_PS_W-1:0] prescale_sel, // controller clock divide select
    input wire rise_event, // rising edge event pulse
    input wire fall_event, // falling edge event pulse
    input wire period_event, // period event pulse
    input wire load_request_bit, // load request set pulse
    input wire rise_dt_we, // write strobe, rising dead time
    input wire fall_dt_we, // write strobe, falling dead time
    input wire [`PDB_DT_MSB:0] dt_wdata, // write data for both registers
    output reg primary_out, // primary switch drive
    output reg compl_out, // complementary switch drive
    output reg [`PDB_DT_MSB:0] rising_dead_time_reg, // written rising value
    output reg [`PDB_DT_MSB:0] falling_dead_time_reg, // written falling value
    output reg [`PDB_DT_MSB:0] rise_dt_active, // rising value in use
    output reg [`PDB_DT_MSB:0] fall_dt_active, // falling value in use
    output reg load_pending, // load request awaiting period
    output wire rise_counting, // rising dead-time count running
    output wire fall_counting // falling dead-time count running
);

    // ============================================================
    // declarations
    wire ctl_tick;
    reg [`PDB_ST_W-1:0] state_q;
    wire [1:0] ch_enable;
    wire [1:0] ch_restart;
    wire [1:0] ch_busy;
    wire [1:0] ch_ins;
    wire [1:0] ch_done;
    wire [`PDB_DT_MSB:0] ch_limit [0:1];
    genvar gi;
    reg frozen_q;
    wire dt_allowed;
    wire rise_ins;
    wire fall_ins;
    wire rise_done;
    wire fall_done;
    wire apply_load;

    // true when the count about to be reached closes the dead time
    function cnt_expired;
        input [`PDB_DT_MSB:0] cnt;
        input [`PDB_DT_MSB:0] limit;
        begin
            cnt_expired = ((cnt + `PDB_DT_ONE) == limit);
        end
    endfunction

    // state decode shared by both channels
    function in_state;
        input [`PDB_ST_W-1:0] st;
        input [`PDB_ST_W-1:0] code;
        begin
            in_state = (st == code);
        end
    endfunction

    // ============================================================
    // controller clock
    pdb_prescale u_prescale (
        .clk(clk),
        .sys_rst(sys_rst),
        .sel(prescale_sel),
        .tick(ctl_tick)
    );

    // ============================================================
    // time registers with buffered update
    // set wins over clear: a load request landing on the period
    // event itself stays pending for the next period
    assign apply_load = period_event & load_pending & ~load_request_bit;

    // written values stand apart from the ones in use, so a write while
    // enabled cannot disturb the running waveform
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rising_dead_time_reg <= `PDB_DT_RST;
            falling_dead_time_reg <= `PDB_DT_RST;
        end else begin
            if (rise_dt_we) begin
                rising_dead_time_reg <= dt_wdata;
            end
            if (fall_dt_we) begin
                falling_dead_time_reg <= dt_wdata;
            end
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rise_dt_active <= `PDB_DT_RST;
            fall_dt_active <= `PDB_DT_RST;
            load_pending <= 1'b0;
        end else begin
            if (load_request_bit) begin
                load_pending <= 1'b1;
            end else if (apply_load || !ctrl_enable) begin
                load_pending <= 1'b0;
            end
            // while disabled the written value is taken at once
            if (!ctrl_enable) begin
                rise_dt_active <= rising_dead_time_reg;
                fall_dt_active <= falling_dead_time_reg;
            end else if (apply_load) begin
                rise_dt_active <= rising_dead_time_reg; // RULE5
                fall_dt_active <= falling_dead_time_reg; // RULE6
            end
        end
    end

    // ============================================================
    // insertion qualifiers, combinational so enables act at once
    assign dt_allowed = comp_mode | bridge_dir_change; // RULE1
    assign ch_enable[0] = rising_dead_time_enable; // RULE7
    assign ch_enable[1] = falling_dead_time_enable; // RULE8
    assign ch_limit[0] = rise_dt_active;
    assign ch_limit[1] = fall_dt_active;
    assign ch_busy[0] = in_state(state_q, `PDB_ST_RISE);
    assign ch_busy[1] = in_state(state_q, `PDB_ST_FALL);
    // a rising event wins when both edges land in one cycle
    assign ch_restart[0] = rise_event; // RULE2
    assign ch_restart[1] = fall_event & ~rise_event; // RULE2

    // ============================================================
    // dead-time channels: index 0 serves rising, 1 falling edges
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
            reg [`PDB_DT_MSB:0] cnt_q;
            // zero count means no deliberate delay; enables act at once
            assign ch_ins[gi] = dt_allowed & ch_enable[gi]
                & (ch_limit[gi] != `PDB_DT_ZERO); // RULE9 RULE16
            // a count ends on its last tick, or at once when insertion
            // is lost
            assign ch_done[gi] = ch_busy[gi] & (~ch_ins[gi]
                | (ctl_tick & cnt_expired(cnt_q, ch_limit[gi])));
            // events are only seen at clk, yet counts step on the slower
            // tick; the phase between them adds up to one controller clock
            // of jitter
            always @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cnt_q <= `PDB_DT_RST;
                end else if (ch_restart[gi]) begin
                    cnt_q <= `PDB_DT_RST; // RULE11
                end else if (ctl_tick && ch_busy[gi]) begin
                    cnt_q <= cnt_q + `PDB_DT_ONE; // RULE10
                end
            end
        end
    endgenerate

    assign rise_ins = ch_ins[0];
    assign fall_ins = ch_ins[1];
    assign rise_done = ch_done[0]; // RULE3
    assign fall_done = ch_done[1]; // RULE4
    assign rise_counting = ch_busy[0];
    assign fall_counting = ch_busy[1];

    // ============================================================
    // output control
    // a rising event wins when both edges arrive in one cycle
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= `PDB_ST_IDLE;
            primary_out <= 1'b0;
            compl_out <= 1'b0;
            frozen_q <= 1'b0;
        end else if (rise_event) begin
            case (state_q)
                `PDB_ST_RISE: begin
                    // outputs hold while the count restarts
                    frozen_q <= 1'b1; // RULE14
                    if (!rise_ins) begin
                        state_q <= `PDB_ST_IDLE;
                        primary_out <= 1'b1;
                        compl_out <= 1'b0;
                        frozen_q <= 1'b0;
                    end
                end
                `PDB_ST_FALL: begin
                    // complementary stays off, switch to rising count
                    compl_out <= 1'b0; // RULE13
                    frozen_q <= 1'b0;
                    if (rise_ins) begin
                        state_q <= `PDB_ST_RISE; // RULE13
                        primary_out <= 1'b0;
                    end else begin
                        state_q <= `PDB_ST_IDLE;
                        primary_out <= 1'b1;
                    end
                end
                default: begin
                    compl_out <= 1'b0; // RULE3
                    frozen_q <= 1'b0;
                    if (rise_ins) begin
                        state_q <= `PDB_ST_RISE; // RULE3
                        primary_out <= 1'b0;
                    end else begin
                        state_q <= `PDB_ST_IDLE;
                        primary_out <= 1'b1; // RULE16
                    end
                end
            endcase
        end else if (fall_event) begin
            case (state_q)
                `PDB_ST_FALL: begin
                    frozen_q <= 1'b1; // RULE14
                    if (!fall_ins) begin
                        state_q <= `PDB_ST_IDLE;
                        primary_out <= 1'b0;
                        compl_out <= comp_mode;
                        frozen_q <= 1'b0;
                    end
                end
                `PDB_ST_RISE: begin
                    // primary stays off, switch to falling count
                    primary_out <= 1'b0; // RULE12
                    frozen_q <= 1'b0;
                    if (fall_ins) begin
                        state_q <= `PDB_ST_FALL; // RULE12
                        compl_out <= 1'b0;
                    end else begin
                        state_q <= `PDB_ST_IDLE;
                        compl_out <= comp_mode;
                    end
                end
                default: begin
                    primary_out <= 1'b0; // RULE4
                    frozen_q <= 1'b0;
                    if (fall_ins) begin
                        state_q <= `PDB_ST_FALL; // RULE4
                        compl_out <= 1'b0;
                    end else begin
                        state_q <= `PDB_ST_IDLE;
                        compl_out <= comp_mode; // RULE16
                    end
                end
            endcase
        end else begin
            case (state_q)
                `PDB_ST_RISE: begin
                    if (rise_done) begin
                        // normal control resumes after a frozen restart
                        state_q <= `PDB_ST_IDLE; // RULE14
                        primary_out <= 1'b1; // RULE3
                        compl_out <= 1'b0;
                        frozen_q <= 1'b0;
                    end
                end
                `PDB_ST_FALL: begin
                    if (fall_done) begin
                        state_q <= `PDB_ST_IDLE; // RULE14
                        primary_out <= 1'b0;
                        compl_out <= comp_mode; // RULE4
                        frozen_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= `PDB_ST_IDLE;
                    frozen_q <= 1'b0;
                    // leaving complementary mode drops the second drive
                    if (!comp_mode) begin
                        compl_out <= 1'b0;
                    end
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### tb/pdb_dead_band_monitor.sv
// checker for the dead-band stage, watching its top-level ports
// assumes one clock domain and one-cycle event pulses
`timescale 1ns/100ps
`default_nettype none
module pdb_dead_band_monitor (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic ctrl_enable, // enabled
    input wire logic comp_mode, // compl mode
    input wire logic bridge_dir_change, // dir change
    input wire logic rising_dead_time_enable, // rise en
    input wire logic falling_dead_time_enable, // fall en
    input wire logic [1:0] prescale_sel, // divide
    input wire logic rise_event, // rise ev
    input wire logic fall_event, // fall ev
    input wire logic period_event, // period ev
    input wire logic load_request_bit, // load
    input wire logic primary_out, // primary
    input wire logic compl_out, // compl
    input wire logic [7:0] rising_dead_time_reg, // rise reg
    input wire logic [7:0] falling_dead_time_reg, // fall reg
    input wire logic [7:0] rise_dt_active, // rise used
    input wire logic [7:0] fall_dt_active, // fall used
    input wire logic load_pending, // pending
    input wire logic rise_counting, // rise busy
    input wire logic fall_counting // fall busy
);
    // ============================================================
    // count cycles with each channel counting since last event; a restart clears the count
    logic [8:0] rc_q;
    logic [8:0] fc_q;
    logic alw;
    assign alw = comp_mode | bridge_dir_change;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rc_q <= 9'h000;
            fc_q <= 9'h000;
        end else if (rise_event | fall_event) begin
            rc_q <= 9'h000;
            fc_q <= 9'h000;
        end else begin
            rc_q <= rc_q + {8'h00, rise_counting};
            fc_q <= fc_q + {8'h00, fall_counting};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ============================================================
    // assertions
    chk_rise_start: assert property (
        rise_event && alw && rising_dead_time_enable && rise_dt_active != 8'h00
        |=> !primary_out && !compl_out && rise_counting && !fall_counting)
        else $error("rising dead time did not start");
    chk_fall_start: assert property (
        fall_event && !rise_event && alw && falling_dead_time_enable
        && fall_dt_active != 8'h00
        |=> !primary_out && !compl_out && fall_counting && !rise_counting)
        else $error("falling dead time did not start");
    chk_rise_len: assert property (
        $fell(rise_counting) && primary_out && prescale_sel == 2'h0
        && rising_dead_time_enable |-> rc_q == {1'b0, rise_dt_active})
        else $error("rising dead time length wrong");
    chk_fall_len: assert property (
        $fell(fall_counting) && compl_out && prescale_sel == 2'h0
        && falling_dead_time_enable |-> fc_q == {1'b0, fall_dt_active})
        else $error("falling dead time length wrong");
    chk_rise_none: assert property (
        rise_event && (!alw || !rising_dead_time_enable || rise_dt_active == 8'h00)
        |=> primary_out && !compl_out && !rise_counting)
        else $error("primary delayed without insertion");
    chk_load_apply: assert property (
        ctrl_enable && load_pending && period_event && !load_request_bit
        |=> rise_dt_active == $past(rising_dead_time_reg) && !load_pending
        && fall_dt_active == $past(falling_dead_time_reg))
        else $error("buffered times not applied");
    chk_load_hold: assert property (
        $past(ctrl_enable) && !$past(period_event)
        |-> $stable(rise_dt_active) && $stable(fall_dt_active))
        else $error("times changed off a period event");
    chk_pend_set: assert property (
        load_request_bit && ctrl_enable |=> load_pending)
        else $error("load request not held");
    chk_same_freeze: assert property (
        rise_event && !fall_event && rise_counting
        |=> $stable(primary_out) && $stable(compl_out) && rise_counting)
        else $error("outputs not frozen on restart");
    cov_fall_in_rise: cover property (fall_event && rise_counting);
    cov_rise_restart: cover property (rise_event && rise_counting);
    cov_load: cover property (period_event && load_pending && ctrl_enable);
endmodule
bind pdb_dead_band pdb_dead_band_monitor pdb_dead_band_monitor_i (
    .clk, .sys_rst, .ctrl_enable, .comp_mode, .bridge_dir_change,
    .rising_dead_time_enable, .falling_dead_time_enable, .prescale_sel,
    .rise_event, .fall_event, .period_event, .load_request_bit,
    .primary_out, .compl_out, .rising_dead_time_reg, .falling_dead_time_reg,
    .rise_dt_active, .fall_dt_active, .load_pending, .rise_counting,
    .fall_counting);
`default_nettype wire

// ### tb/pdb_gate_model.sv
// gate-driver pair model: measures the both-off gap before a turn-on
// assumes high means switch on, sampled on the source clock
`timescale 1ns/100ps
`default_nettype none
module pdb_gate_model (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic primary_on, // primary gate
    input wire logic compl_on, // compl gate
    output logic [8:0] gap_q, // off cycles before turn-on
    output logic [7:0] shoot_q // cycles both on
);
    logic [8:0] idle_q;
    logic p_q;
    logic c_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_q <= 9'h000;
            p_q <= 1'b0;
            c_q <= 1'b0;
            gap_q <= 9'h000;
            shoot_q <= 8'h00;
        end else begin
            p_q <= primary_on;
            c_q <= compl_on;
            idle_q <= (primary_on | compl_on) ? 9'h000 : idle_q + 9'h001;
            // a turn-on right as the other side turns off is a zero gap
            if ((primary_on && !p_q) || (compl_on && !c_q)) gap_q <= idle_q;
            // both on would short the supply through the pair
            if (primary_on && compl_on) shoot_q <= shoot_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench of the dead-band stage with a gate-driver model
// assumes the checker is bound to the design by its own file
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, ctrl_enable = 1'b0;
    logic rise_dt_we = 1'b0, fall_dt_we = 1'b0;
    logic [3:0] md = 4'hB, evt = 4'h0;
    logic [1:0] prescale_sel = 2'h0;
    logic [7:0] dt_wdata = 8'h00;
    wire primary_out, compl_out, load_pending, rise_counting, fall_counting;
    wire [7:0] rising_dead_time_reg, falling_dead_time_reg;
    wire [7:0] rise_dt_active, fall_dt_active, shoot_q;
    wire [8:0] gap_q;
    int fail_count = 0, check_count = 0, cyc = 0;
    logic [7:0] vals [4] = '{8'h00, 8'h01, 8'h05, 8'hFF};
    // mode, bridge, rise en, fall en, rise event, counting expected
    logic [5:0] tbl [5] = '{6'h26, 6'h28, 6'h0E, 6'h1F, 6'h2F};
    always #12.5 clk = ~clk;
    pdb_dead_band pdb_dead_band_i (.clk, .sys_rst, .ctrl_enable,
        .comp_mode(md[3]), .bridge_dir_change(md[2]),
        .rising_dead_time_enable(md[1]), .falling_dead_time_enable(md[0]),
        .prescale_sel, .rise_event(evt[3]), .fall_event(evt[2]),
        .period_event(evt[1]), .load_request_bit(evt[0]), .rise_dt_we,
        .fall_dt_we, .dt_wdata, .primary_out, .compl_out,
        .rising_dead_time_reg, .falling_dead_time_reg, .rise_dt_active,
        .fall_dt_active, .load_pending, .rise_counting, .fall_counting);
    pdb_gate_model pdb_gate_model_i (.clk, .sys_rst, .primary_on(primary_out),
        .compl_on(compl_out), .gap_q, .shoot_q);
    // ============================================================
    // tasks
    task chk(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic r, input logic f, input logic [7:0] d);
        @(negedge clk);
        rise_dt_we = r;
        fall_dt_we = f;
        dt_wdata = d;
        @(negedge clk);
        rise_dt_we = 1'b0;
        fall_dt_we = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task ev(input logic [3:0] e);
        @(negedge clk);
        evt = e;
        @(negedge clk);
        evt = 4'h0;
    endtask
    task settle;
        int i;
        for (i = 0; i < 600 && (rise_counting | fall_counting) !== 1'b0; i++)
            @(negedge clk);
        repeat (2) @(negedge clk);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // the whole run needs under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fail_count++;
            end_of_test;
        end
    end
    // ============================================================
    // tests
    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        ev(4'h8);
        settle;
        foreach (vals[k]) begin
            wr(1'b1, 1'b1, vals[k]);
            chk(rising_dead_time_reg, vals[k]);
            chk(fall_dt_active, vals[k]);
            ev(4'h4);
            settle;
            chk(gap_q, vals[k]);
            ev(4'h8);
            settle;
            chk(gap_q, vals[k]);
        end
        $display("test dead times done");
        wr(1'b1, 1'b1, 8'h04);
        foreach (tbl[k]) begin
            md = tbl[k][5:2];
            ev(tbl[k][1] ? 4'h8 : 4'h4);
            chk(tbl[k][1] ? rise_counting : fall_counting, tbl[k][0]);
            settle;
        end
        ev(4'h8);
        md[1] = 1'b0;
        repeat (2) @(negedge clk);
        chk(primary_out, 1'b1);
        md[1] = 1'b1;
        $display("test enables done");
        ctrl_enable = 1'b1;
        wr(1'b1, 1'b0, 8'h07);
        wr(1'b0, 1'b1, 8'h09);
        ev(4'h2);
        chk(rise_dt_active, 8'h04);
        ev(4'h1);
        chk(load_pending, 1'b1);
        ev(4'h2);
        chk(rise_dt_active, 8'h07);
        chk(fall_dt_active, 8'h09);
        chk(falling_dead_time_reg, 8'h09);
        wr(1'b0, 1'b1, 8'h06);
        ev(4'h3);
        chk(fall_dt_active, 8'h09);
        chk(load_pending, 1'b1);
        ev(4'h2);
        chk(fall_dt_active, 8'h06);
        $display("test buffered load done");
        ev(4'h4);
        repeat (2) @(negedge clk);
        ev(4'h8);
        chk({compl_out, rise_counting, fall_counting}, 3'h2);
        repeat (2) @(negedge clk);
        ev(4'h4);
        chk({primary_out, fall_counting, rise_counting}, 3'h2);
        settle;
        ev(4'h8);
        repeat (2) @(negedge clk);
        ev(4'h8);
        settle;
        chk(gap_q, 9'h00B);
        $display("test overlap done");
        ctrl_enable = 1'b0;
        prescale_sel = 2'h3;
        wr(1'b1, 1'b1, 8'h03);
        ev(4'h4);
        settle;
        chk(gap_q >= 9'h010 && gap_q <= 9'h019, 1'b1);
        chk(shoot_q, 8'h00);
        $display("test prescaler done");
        end_of_test;
    end
endmodule
`default_nettype wire
